// ===== logic/ssc_switch_sync.sv
// Purpose: switch synchronizer with antivalence check and error output combiner
// Assumes: inputs synchronous to ref_clk; one logic cycle per clock
// Notes: registers over APB; hold time in 10 ms steps
// Notes on behaviour
// - Hold time 10 ms to 10 s, 10 ms steps
// - Inverted input complemented, output too
// - One to six inputs, three pairs
// - Input change starts timer, outputs hold
// - Expiry copies inputs to outputs regardless
// - Cascade output exists when cascade configured
// - Cascade rising edge starts timer
// - Marker feedback: timer extended one cycle
// - Expiry checks pairs, non-complement sets error
// - Error clears on clean later synchronization
// - Error output only when check enabled
// - Stop to Run loads outputs immediately
// - One or two error inputs force outputs
// - Combiner one to six channels, per-bit value
`include "ssc_defs.svh"
module ssc_switch_sync (
  input wire logic ref_clk, // 10 MHz clock
  input wire logic reset, // Async reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [5:0] syncIn, // Pair inputs 1A,1B,2A,2B,3A,3B
  input wire logic cascadeIn, // Cascade input
  output logic [5:0] syncOut, // Synchronized outputs
  output logic cascadeOut, // Cascade output
  output logic antivalenceErr, // Antivalence error
  input wire logic [5:0] combData, // Combiner data inputs
  input wire logic [1:0] combErrIn, // Combiner error inputs
  output logic [5:0] combOut // Combiner outputs
);

  ssc_pkg::ssc_cfg_s cfg;
  logic [9:0] holdSteps;
  ssc_pkg::ssc_chan_t invMask;
  ssc_pkg::ssc_chan_t errCombo;
  ssc_pkg::ssc_state_e state;
  ssc_pkg::ssc_chan_t prevIn;
  logic prevCasc;
  logic [26:0] holdCnt;
  logic [26:0] holdLoad;
  ssc_pkg::ssc_chan_t usedMask;
  ssc_pkg::ssc_chan_t usedCh;
  ssc_pkg::ssc_chan_t evalIn;
  logic inChange;
  logic cascRise;
  logic startTimer;
  logic latchNow;
  logic pairBad;
  logic runRise;
  logic prevRun;
  logic anyErr;
  logic [9:0] holdW;
  logic wrCtrl;
  logic wrHold;
  logic wrInv;
  logic wrComb;
  logic [31:0] next_prdata;
  logic [2:0] pairFault;

  function automatic ssc_pkg::ssc_chan_t countMask(input logic [2:0] n);
    ssc_pkg::ssc_chan_t m;
    m = '0;
    for (int i = 0; i < 6; i++)
    begin
      if (i < int'(n))
        m[i] = 1'b1;
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states

  wire apbWr = psel && penable && pwrite;
  wire apbRd = psel && !penable && !pwrite;
  wire addrOk = (paddr == `SSC_OFS_CTRL) || (paddr == `SSC_OFS_HOLD) ||
    (paddr == `SSC_OFS_INV) || (paddr == `SSC_OFS_COMB) || (paddr == `SSC_OFS_STAT);

  // Clamp keeps hold inside the documented span
  always_comb
  begin
    holdW = pwdata[9:0];
    if (holdW < `SSC_HOLD_MIN)
      holdW = `SSC_HOLD_MIN;
    else if (holdW > `SSC_HOLD_MAX)
      holdW = `SSC_HOLD_MAX;
  end

  // One strobe per register; unmapped and status offsets strobe nothing
  always_comb
  begin
    wrCtrl = apbWr && (paddr == `SSC_OFS_CTRL);
    wrHold = apbWr && (paddr == `SSC_OFS_HOLD);
    wrInv = apbWr && (paddr == `SSC_OFS_INV);
    wrComb = apbWr && (paddr == `SSC_OFS_COMB);
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      cfg <= ssc_pkg::ssc_cfg_s'(11'(`SSC_CTRL_RST));
    else if (wrCtrl)
    begin
      cfg.run <= pwdata[`SSC_CTRL_RUN];
      cfg.cascEn <= pwdata[`SSC_CTRL_CASC];
      cfg.avChkEn <= pwdata[`SSC_CTRL_AVCHK];
      cfg.viaMarker <= pwdata[`SSC_CTRL_MARK];
      cfg.numIn <= pwdata[`SSC_CTRL_NUMIN +: 3];
      cfg.twoErr <= pwdata[`SSC_CTRL_TWOERR];
      cfg.numCh <= pwdata[`SSC_CTRL_NUMCH +: 3];
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      holdSteps <= `SSC_HOLD_RST;
    else if (wrHold)
      holdSteps <= holdW;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      invMask <= 6'h00;
    else if (wrInv)
      invMask <= pwdata[5:0];
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      errCombo <= 6'h00;
    else if (wrComb)
      errCombo <= pwdata[5:0];
  end

  // Picked in the setup cycle so it stands through the access cycle
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (apbRd)
    begin
      case (paddr)
        `SSC_OFS_CTRL: next_prdata = {21'h0, cfg.numCh, cfg.twoErr, cfg.numIn,
          cfg.viaMarker, cfg.avChkEn, cfg.cascEn, cfg.run};
        `SSC_OFS_HOLD: next_prdata = {22'h0, holdSteps};
        `SSC_OFS_INV: next_prdata = {26'h0, invMask};
        `SSC_OFS_COMB: next_prdata = {26'h0, errCombo};
        `SSC_OFS_STAT: next_prdata = {14'h0, combOut, 2'h0, syncOut,
          state, antivalenceErr, cascadeOut};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addrOk;
      prdata <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronizer

  always_comb
  begin
    usedMask = countMask(cfg.numIn);
    usedCh = countMask(cfg.numCh);
    evalIn = (syncIn ^ invMask) & usedMask;
  end

  always_comb
  begin
    inChange = (evalIn != prevIn);
    cascRise = cfg.cascEn && cascadeIn && !prevCasc;
    // Cascade mode follows the shared edge only
    startTimer = cfg.cascEn ? cascRise : inChange;
    runRise = cfg.run && !prevRun;
  end

  always_comb
  begin
    latchNow = runRise || (state == ssc_pkg::SSC_HOLD && holdCnt == 27'h0000000);
  end

  // A pair counts once its second input is in use
  for (genvar p = 0; p < 3; p++)
  begin : g_pair
    assign pairFault[p] = usedMask[2 * p + 1] && (evalIn[2 * p] == evalIn[2 * p + 1]);
  end

  assign pairBad = |pairFault;

  // Ten seconds of hold needs 27 bits; narrower would wrap
  always_comb
  begin
    // Marker adds one cycle of feedback delay; start value is the prior cycle
    holdLoad = 27'(holdSteps) * 27'(`SSC_HOLD_STEP_CYC) - 27'h0000002 +
      ((cfg.cascEn && cfg.viaMarker) ? 27'h0000001 : 27'h0000000);
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      prevIn <= 6'h00;
      prevCasc <= 1'b0;
      prevRun <= 1'b0;
    end
    else
    begin
      prevIn <= evalIn;
      prevCasc <= cascadeIn;
      prevRun <= cfg.run;
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      state <= ssc_pkg::SSC_STOP;
    else if (!cfg.run)
      state <= ssc_pkg::SSC_STOP;
    else
    begin
      case (state)
        ssc_pkg::SSC_STOP: state <= ssc_pkg::SSC_IDLE;
        ssc_pkg::SSC_IDLE:
        begin
          if (startTimer)
            state <= ssc_pkg::SSC_HOLD;
        end
        ssc_pkg::SSC_HOLD:
        begin
          if (holdCnt == 27'h0000000)
            state <= ssc_pkg::SSC_IDLE;
        end
        default: state <= ssc_pkg::SSC_STOP;
      endcase
    end
  end

  // Changes while holding do not reload the counter
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      holdCnt <= 27'h0000000;
    else if (!cfg.run)
      holdCnt <= 27'h0000000;
    else if (state == ssc_pkg::SSC_IDLE && startTimer)
      holdCnt <= holdLoad;
    else if (state == ssc_pkg::SSC_HOLD && holdCnt != 27'h0000000)
      holdCnt <= holdCnt - 27'h0000001;
  end

  // Outputs move only on expiry or at start of run
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      syncOut <= 6'h00;
    else if (latchNow)
      syncOut <= evalIn;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      antivalenceErr <= 1'b0;
    else if (!cfg.avChkEn)
      antivalenceErr <= 1'b0;
    else if (latchNow)
      antivalenceErr <= pairBad;
  end

  // Pulses on any change so a peer can share the hold window
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      cascadeOut <= 1'b0;
    else
      cascadeOut <= cfg.cascEn && cfg.run && inChange;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error output combiner

  always_comb
  begin
    anyErr = combErrIn[0] || (cfg.twoErr && combErrIn[1]);
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      combOut <= 6'h00;
    else if (anyErr)
      combOut <= errCombo & usedCh;
    else
      combOut <= combData & usedCh;
  end

endmodule

// ===== logic/ssc_defs.svh
// Purpose: timing counts, register offsets and reset values for the switch synchronizer
// Assumes: ref_clk at 10 MHz (100 ns period)
// Notes: all offsets are byte addresses on APB
`ifndef SSC_DEFS_SVH
`define SSC_DEFS_SVH
`define SSC_CLK_HZ 10000000
`define SSC_HOLD_STEP_MS 10
`define SSC_HOLD_STEP_CYC ((`SSC_CLK_HZ / 1000) * `SSC_HOLD_STEP_MS)
`define SSC_HOLD_MIN 10'h001
`define SSC_HOLD_MAX 10'h3e8
`define SSC_OFS_CTRL 12'h000
`define SSC_OFS_HOLD 12'h004
`define SSC_OFS_INV 12'h008
`define SSC_OFS_COMB 12'h00c
`define SSC_OFS_STAT 12'h010
`define SSC_CTRL_RUN 0
`define SSC_CTRL_CASC 1
`define SSC_CTRL_AVCHK 2
`define SSC_CTRL_MARK 3
`define SSC_CTRL_NUMIN 4
`define SSC_CTRL_TWOERR 7
`define SSC_CTRL_NUMCH 8
`define SSC_CTRL_RST 32'h0000_0000
`define SSC_HOLD_RST 10'h001
`endif

// ===== logic/ssc_pkg.sv
// Purpose: types for the switch synchronizer and error combiner
// Assumes: nothing
// Notes: six channels, three A/B pairs
package ssc_pkg;
  typedef logic [5:0] ssc_chan_t;
  typedef enum logic [1:0] {
    SSC_STOP = 2'b00,
    SSC_IDLE = 2'b01,
    SSC_HOLD = 2'b11
  } ssc_state_e;
  typedef struct packed {
    logic run;
    logic cascEn;
    logic avChkEn;
    logic viaMarker;
    logic [2:0] numIn;
    logic twoErr;
    logic [2:0] numCh;
  } ssc_cfg_s;
endpackage

// ===== tb/ssc_contacts.sv
// Purpose: switch contacts on the synchronizer inputs
// Assumes: one contact moves per clock
// Notes: contacts never switch together, so a move of two or more contacts is always skewed
module ssc_contacts (
  input wire logic clk, // Clock
  input wire logic [5:0] target, // Final switch position
  output logic [5:0] pins // Contact levels
);
  initial pins = 6'h00;
  always @(posedge clk)
  begin
    for (int i = 0; i < 6; i++)
    begin
      if (pins[i] != target[i])
      begin
        pins[i] <= target[i];
        break;
      end
    end
  end
endmodule

// ===== tb/ssc_switch_sync_checker.sv
// Purpose: port checks for the switch synchronizer
// Assumes: one clock, async reset
// Notes: bind at the foot
module ssc_switch_sync_checker (
  input wire logic ref_clk, // Clock
  input wire logic reset, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic [5:0] syncIn, // Inputs
  input wire logic [5:0] syncOut, // Outputs
  input wire logic antivalenceErr, // Pair error
  input wire logic [5:0] combData, // Comb data
  input wire logic [1:0] combErrIn, // Comb errors
  input wire logic [5:0] combOut // Comb outputs
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_change;
    $changed(syncIn);
  endsequence
  property p_rdy_after; s_setup ##1 (psel && penable) |-> pready; endproperty
  property p_rdy_cause; pready |-> $past(psel && !penable); endproperty
  property p_rdy_one; pready |=> !pready; endproperty
  property p_err_rdy; pslverr |-> pready; endproperty
  property p_hold_out; s_change |=> $stable(syncOut) [*8]; endproperty
  property p_hold_err; s_change |=> $stable(antivalenceErr) [*8]; endproperty
  property p_pass; combErrIn == 2'h0 |=> (combOut & ~$past(combData)) == 6'h00; endproperty
  property p_quiet; $fell(reset) |-> syncOut == 6'h00 && combOut == 6'h00; endproperty
  a_rdy_after: assert property (p_rdy_after) else $error("no ready after setup");
  a_rdy_cause: assert property (p_rdy_cause) else $error("ready without setup");
  a_rdy_one: assert property (p_rdy_one) else $error("ready too long");
  a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
  a_hold_out: assert property (p_hold_out) else $error("output moved early");
  a_hold_err: assert property (p_hold_err) else $error("error moved early");
  a_pass: assert property (p_pass) else $error("combiner output not data");
  a_quiet: assert property (p_quiet) else $error("outputs not clear");
endmodule
bind ssc_switch_sync ssc_switch_sync_checker chk (.ref_clk, .reset, .psel, .penable,
  .pready, .pslverr, .syncIn, .syncOut, .antivalenceErr, .combData, .combErrIn, .combOut);

// ===== tb/testbench.sv
// Purpose: register, combiner and synchronizer tests
// Assumes: hold of one step is 100000 clocks
// Notes: one full hold expiry dominates the run time
`include "ssc_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, cascadeIn = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, antivalenceErr, cascadeOut, se, sawCasc = 0;
  logic [5:0] syncIn, syncOut, combOut, combData = 6'h00, target = 6'h00;
  logic [1:0] combErrIn = 2'h0;
  int errors = 0, nCompared = 0, cnt;
  ssc_switch_sync dut (.ref_clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .syncIn(syncIn), .cascadeIn(cascadeIn), .syncOut(syncOut),
    .cascadeOut(cascadeOut), .antivalenceErr(antivalenceErr), .combData(combData),
    .combErrIn(combErrIn), .combOut(combOut));
  ssc_contacts model (.clk(clk), .target(target), .pins(syncIn));
  // One block alone, so one hold time; marker gives one cycle of feedback
  always @(posedge clk) cascadeIn <= cascadeOut;
  always @(posedge clk) if (cascadeOut === 1'b1) sawCasc <= 1'b1;
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compared %0d, mismatches %0d", nCompared, errors);
    if (errors == 0 && nCompared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    nCompared++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) errors++;
    rd = prdata;
    se = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
    chk({31'h0, se}, 32'h0);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial forever #50 clk = ~clk;
  initial
  begin
    #12_000_000;
    errors++;
    summarize();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rdchk(`SSC_OFS_CTRL, `SSC_CTRL_RST);
    rdchk(`SSC_OFS_HOLD, {22'h0, `SSC_HOLD_RST});
    apb(1'b1, 12'h020, 32'h5);
    apb(1'b0, 12'h020, 32'h0);
    chk({rd[30:0], se}, 32'h1);
    apb(1'b1, `SSC_OFS_HOLD, 32'h7ff);
    rdchk(`SSC_OFS_HOLD, {22'h0, `SSC_HOLD_MAX});
    apb(1'b1, `SSC_OFS_HOLD, 32'h0);
    rdchk(`SSC_OFS_HOLD, {22'h0, `SSC_HOLD_MIN});
    $display("test registers done");
    combData <= 6'h15;
    apb(1'b1, `SSC_OFS_COMB, 32'h2a);
    apb(1'b1, `SSC_OFS_CTRL, 32'h680);
    tick(2);
    chk(combOut, 32'h15);
    @(posedge clk) combErrIn <= 2'h2;
    tick(2);
    chk(combOut, 32'h2a);
    apb(1'b1, `SSC_OFS_CTRL, 32'h300);
    tick(2);
    chk(combOut, 32'h05);
    @(posedge clk) combErrIn <= 2'h1;
    tick(2);
    chk(combOut, 32'h02);
    $display("test combiner done");
    target <= 6'h19;
    apb(1'b1, `SSC_OFS_INV, 32'h1);
    tick(8);
    apb(1'b1, `SSC_OFS_CTRL, 32'h665);
    tick(1);
    chk(syncOut, 32'h18);
    chk(antivalenceErr, 32'h1);
    @(posedge clk) target <= 6'h1b;
    tick(1000);
    chk(syncOut, 32'h18);
    cnt = 1000;
    while (syncOut === 6'h18 && cnt < 101000)
    begin
      @(negedge clk);
      cnt++;
    end
    chk((cnt + 500) / 1000, 32'd100);
    chk(syncOut, 32'h1a);
    chk(antivalenceErr, 32'h0);
    $display("test hold done");
    apb(1'b1, `SSC_OFS_CTRL, 32'h667);
    @(posedge clk) target <= 6'h19;
    tick(4);
    chk(sawCasc, 32'h1);
    apb(1'b0, `SSC_OFS_STAT, 32'h0);
    chk(rd[3:2], 32'h3);
    $display("test cascade done");
    summarize();
  end
endmodule
